// file: wdt_pkg.sv
// constants, types and register map of the watchdog key block
package wdt_pkg;

    // ------------------------------------------------------------------
    // register indices, byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [9:0]  IDX_CTRL_STATUS = 10'h0A7;
    localparam logic [9:0]  IDX_KEY         = 10'h0A6;
    localparam logic [9:0]  IDX_IRQ_STATUS  = 10'h0A8;
    localparam logic [9:0]  IDX_IRQ_MASK    = 10'h0A9;
    localparam int          ADDR_W          = 12;

    // ------------------------------------------------------------------
    // key bytes
    // ------------------------------------------------------------------
    localparam logic [7:0]  KEY_FEED_FIRST  = 8'h1E;
    localparam logic [7:0]  KEY_FEED_SECOND = 8'hE1;
    localparam logic [7:0]  KEY_SOFT_FIRST  = 8'h5A;
    localparam logic [7:0]  KEY_SOFT_SECOND = 8'hA5;

    // ------------------------------------------------------------------
    // timing: timeout = 2^(ps + 14) cycles = prescaler * 2^(ps + 7)
    // ------------------------------------------------------------------
    localparam int          PRESCALE_BITS   = 7;
    localparam int          COUNT_BITS      = 14;
    localparam logic [3:0]  PERIOD_BASE_EXP = 4'h7;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;
    localparam int          IRQ_W           = 4;

    // interrupt status bit positions
    localparam int          IRQ_SOFT_RESET  = 0;
    localparam int          IRQ_KEY_ERROR   = 1;
    localparam int          IRQ_TIMEOUT     = 2;
    localparam int          IRQ_FED         = 3;

    // control/status layout, msb first
    typedef struct packed {
        logic [2:0] period_select;
        logic       idle_freeze;
        logic       reserved;
        logic       soft_reset_cause_flag;
        logic       overflow_cause_flag;
        logic       watchdog_running;
    } ctrl_s;

    // one apb request as presented by the master
    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic              pwrite;
        logic [31:0]       pwdata;
    } apb_req_s;

    typedef enum logic [1:0] {
        KEY_IDLE = 2'b00,
        KEY_FEED = 2'b01,
        KEY_SOFT = 2'b10
    } key_state_e;

endpackage : wdt_pkg

// file: wdt_tick_div.sv
// free divider that gives a one-cycle enable pulse every 2^WIDTH cycles
`timescale 1ns/1ns
module wdt_tick_div #(
    parameter int WIDTH = 7
) (
    input  wire logic clk_sys,
    input  wire logic rst_n,
    input  wire logic run,
    input  wire logic clr,
    output logic      tick
);

    logic [WIDTH-1:0] cnt_q;
    logic [WIDTH-1:0] cnt_d;

    // terminal count marks the tick, hold while not running
    assign tick  = run && (cnt_q == {WIDTH{1'b1}});
    assign cnt_d = clr ? '0 : (run ? cnt_q + 1'b1 : cnt_q);

    // counter state
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule : wdt_tick_div

// file: wdt_sticky.sv
// sticky flag bank, set by hardware, cleared by writing a one
`timescale 1ns/1ns
module wdt_sticky #(
    parameter int W = 4
) (
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    output logic [W-1:0]      q
);

    logic [W-1:0] q_d;

    // a set in the clearing cycle wins so no event is lost
    assign q_d = set | (q & ~clr);

    // flag storage
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= q_d;
        end
    end

endmodule : wdt_sticky

// file: wdt_key_ctrl.sv
// watchdog key sequencer, counter, cause flags and apb register slave
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ns
module wdt_key_ctrl #(
    parameter int PRESCALE_W = wdt_pkg::PRESCALE_BITS
) (
    input  wire logic                      clk_sys,
    input  wire logic                      rst_n,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [wdt_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      cpu_idle,
    input  wire logic                      power_down,
    output logic                           cpu_reset_pulse,
    output logic                           watchdog_running,
    output logic                           irq
);
    import wdt_pkg::*;

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    apb_req_s          req;
    ctrl_s             ctrl_q;
    ctrl_s             ctrl_d;
    key_state_e        key_q;
    key_state_e        key_d;
    logic [COUNT_BITS-1:0] cnt_q;
    logic [COUNT_BITS-1:0] cnt_d;
    logic [IRQ_W-1:0]  irq_mask_q;
    logic [IRQ_W-1:0]  irq_stat;
    logic [IRQ_W-1:0]  irq_set;
    logic [IRQ_W-1:0]  irq_clr;
    logic [31:0]       prdata_q;
    logic [31:0]       rdata_w;
    logic              pready_q;
    logic              pslverr_q;
    logic              rst_pulse_q;
    logic              irq_q;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    logic [ADDR_W-1:0] a_ctrl;
    logic [ADDR_W-1:0] a_key;
    logic [ADDR_W-1:0] a_istat;
    logic [ADDR_W-1:0] a_imask;
    logic              access;
    logic              done;
    logic              hit_ctrl;
    logic              hit_key;
    logic              hit_istat;
    logic              hit_imask;
    logic              mapped;
    logic              wr_ok;
    logic              wr_ctrl;
    logic              wr_key;
    logic              wr_istat;
    logic              wr_imask;
    logic              wr_other;
    logic [7:0]        key_byte;

    assign req      = '{paddr: paddr, pwrite: pwrite, pwdata: pwdata};
    assign a_ctrl   = ADDR_W'({IDX_CTRL_STATUS, 2'b00});
    assign a_key    = ADDR_W'({IDX_KEY, 2'b00});
    assign a_istat  = ADDR_W'({IDX_IRQ_STATUS, 2'b00});
    assign a_imask  = ADDR_W'({IDX_IRQ_MASK, 2'b00});

    // one wait state: pready rises in the second access cycle
    assign access   = psel && penable;
    assign done     = access && pready_q;

    // address match, parallel compares kept in a function-free form
    assign hit_ctrl  = (req.paddr == a_ctrl);
    assign hit_key   = (req.paddr == a_key);
    assign hit_istat = (req.paddr == a_istat);
    assign hit_imask = (req.paddr == a_imask);
    assign mapped    = hit_ctrl || hit_key || hit_istat || hit_imask;

    // writes take effect only at the completing edge
    assign wr_ok    = done && req.pwrite && mapped;
    assign wr_ctrl  = wr_ok && hit_ctrl;
    assign wr_key   = wr_ok && hit_key;
    assign wr_istat = wr_ok && hit_istat;
    assign wr_imask = wr_ok && hit_imask;
    assign wr_other = wr_ok && !hit_key;
    assign key_byte = req.pwdata[7:0];

    // ------------------------------------------------------------------
    // key sequencer
    // ------------------------------------------------------------------
    logic feed_ok;
    logic soft_ok;
    logic key_err;
    logic seq_break;

    // a register write between the two key bytes spoils the pair
    assign seq_break = wr_other && (key_q != KEY_IDLE);

    always_comb begin
        key_d   = key_q;
        feed_ok = 1'b0;
        soft_ok = 1'b0;
        key_err = 1'b0;
        case (key_q)
            KEY_IDLE: begin
                if (wr_key) begin
                    if (key_byte == KEY_FEED_FIRST) begin
                        key_d = KEY_FEED;
                    end else if (key_byte == KEY_SOFT_FIRST) begin
                        key_d = KEY_SOFT;
                    end else begin
                        key_err = 1'b1;
                    end
                end
            end
            KEY_FEED: begin
                if (seq_break) begin
                    key_d   = KEY_IDLE;
                    key_err = 1'b1;
                end else if (wr_key) begin
                    key_d   = KEY_IDLE;
                    feed_ok = (key_byte == KEY_FEED_SECOND);
                    key_err = (key_byte != KEY_FEED_SECOND);
                end
            end
            KEY_SOFT: begin
                if (seq_break) begin
                    key_d   = KEY_IDLE;
                    key_err = 1'b1;
                end else if (wr_key) begin
                    key_d   = KEY_IDLE;
                    // honoured even with the counter stopped
                    soft_ok = (key_byte == KEY_SOFT_SECOND);
                    key_err = (key_byte != KEY_SOFT_SECOND);
                end
            end
            default: begin
                key_d = KEY_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // prescaler and timeout counter
    // ------------------------------------------------------------------
    logic                  count_en;
    logic                  tick;
    logic                  timeout;
    logic                  any_reset;
    logic [COUNT_BITS:0]   span;
    logic [COUNT_BITS-1:0] limit;
    logic [3:0]            exp_w;

    // freeze in idle only when asked, never count in power-down
    assign count_en = ctrl_q.watchdog_running && !power_down
                   && !(cpu_idle && ctrl_q.idle_freeze);

    // limit = 2^(ps + 7) - 1 ticks, doubling per code step
    assign exp_w = PERIOD_BASE_EXP + {1'b0, ctrl_q.period_select};
    assign span  = (COUNT_BITS+1)'(1) << exp_w;
    assign limit = COUNT_BITS'(span - 1'b1);

    assign timeout   = tick && (cnt_q == limit);
    assign any_reset = timeout || soft_ok || key_err;

    wdt_tick_div #(
        .WIDTH (PRESCALE_W)
    ) u_prescale (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .run     (count_en),
        .clr     (feed_ok || any_reset),
        .tick    (tick)
    );

    // a feed restarts from zero; any reset stops and clears
    assign cnt_d = (feed_ok || any_reset) ? '0 :
                   (tick ? cnt_q + 1'b1 : cnt_q);

    // ------------------------------------------------------------------
    // control/status register
    // ------------------------------------------------------------------
    logic clr_soft;
    logic clr_ovf;

    // software clears a cause flag by writing zero to it
    assign clr_soft = wr_ctrl && !req.pwdata[2];
    assign clr_ovf  = wr_ctrl && !req.pwdata[1];

    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d.period_select = req.pwdata[7:5];
            ctrl_d.idle_freeze   = req.pwdata[4];
        end
        ctrl_d.reserved = 1'b0;
        // set beats clear; flags are not touched by the reset they cause
        ctrl_d.soft_reset_cause_flag = soft_ok || key_err
            || (ctrl_q.soft_reset_cause_flag && !clr_soft);
        ctrl_d.overflow_cause_flag = key_err || timeout
            || (ctrl_q.overflow_cause_flag && !clr_ovf);
        if (any_reset || power_down) begin
            ctrl_d.watchdog_running = 1'b0;
        end else if (feed_ok) begin
            ctrl_d.watchdog_running = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------------
    assign irq_set[IRQ_SOFT_RESET] = soft_ok;
    assign irq_set[IRQ_KEY_ERROR]  = key_err;
    assign irq_set[IRQ_TIMEOUT]    = timeout;
    assign irq_set[IRQ_FED]        = feed_ok;
    assign irq_clr = wr_istat ? req.pwdata[IRQ_W-1:0] : '0;

    wdt_sticky #(
        .W (IRQ_W)
    ) u_irq_stat (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .set     (irq_set),
        .clr     (irq_clr),
        .q       (irq_stat)
    );

    // ------------------------------------------------------------------
    // read mux, key register reads as zero
    // ------------------------------------------------------------------
    always_comb begin
        rdata_w = '0;
        if (hit_ctrl) begin
            rdata_w[7:0] = ctrl_q;
        end else if (hit_istat) begin
            rdata_w[IRQ_W-1:0] = irq_stat;
        end else if (hit_imask) begin
            rdata_w[IRQ_W-1:0] = irq_mask_q;
        end else begin
            rdata_w = '0;
        end
    end

    // ------------------------------------------------------------------
    // apb handshake flops
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= '0;
        end else begin
            pready_q  <= access && !pready_q;
            pslverr_q <= access && !pready_q && !mapped;
            if (access && !pready_q && !req.pwrite) begin
                prdata_q <= rdata_w;
            end
        end
    end

    // ------------------------------------------------------------------
    // block state flops
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            key_q      <= KEY_IDLE;
            ctrl_q     <= CTRL_RESET;
            cnt_q      <= '0;
            irq_mask_q <= '0;
        end else begin
            key_q  <= key_d;
            ctrl_q <= ctrl_d;
            cnt_q  <= cnt_d;
            if (wr_imask) begin
                irq_mask_q <= req.pwdata[IRQ_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------------
    // one-cycle reset pulse towards the cpu core
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_pulse_q <= 1'b0;
            irq_q       <= 1'b0;
        end else begin
            rst_pulse_q <= any_reset;
            // or before and, so the mask also covers a fresh event
            irq_q       <= |((irq_set | (irq_stat & ~irq_clr))
                                      & irq_mask_q);
        end
    end

    assign prdata           = prdata_q;
    assign pready           = pready_q;
    assign pslverr          = pslverr_q;
    assign cpu_reset_pulse  = rst_pulse_q;
    assign watchdog_running = ctrl_q.watchdog_running;
    assign irq              = irq_q;

endmodule : wdt_key_ctrl

// file: wdt_key_ctrl_properties.sv
// port-level checker of the watchdog key block
`timescale 1ns/1ns
module wdt_key_ctrl_properties #(
    parameter int PRESCALE_W = wdt_pkg::PRESCALE_BITS
) (
    input wire logic                       clk_sys,
    input wire logic                       rst_n,
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [wdt_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0]                pwdata,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    input wire logic                       cpu_idle,
    input wire logic                       power_down,
    input wire logic                       cpu_reset_pulse,
    input wire logic                       watchdog_running,
    input wire logic                       irq
);
    import wdt_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------------------------------
    // key pair tracking, mirrors what software has committed
    // ----------------------------------------------------------------
    logic       pend_q;
    logic       pend_d;
    logic [7:0] first_q;
    logic [7:0] first_d;
    wire logic [11:0] key_a  = {IDX_KEY, 2'b00};
    wire logic [7:0]  kb     = pwdata[7:0];
    wire logic commit   = psel && penable && pready && pwrite && !pslverr;
    wire logic key_wr   = commit && (paddr == key_a);
    wire logic other_wr = commit && (paddr != key_a);
    wire logic first_ok = kb == KEY_FEED_FIRST || kb == KEY_SOFT_FIRST;
    wire logic good_feed = key_wr && pend_q && first_q == KEY_FEED_FIRST
                           && kb == KEY_FEED_SECOND;
    wire logic good_soft = key_wr && pend_q && first_q == KEY_SOFT_FIRST
                           && kb == KEY_SOFT_SECOND;
    // unmapped writes never reach commit, so they leave a pair intact
    wire logic bad = (key_wr && !pend_q && !first_ok)
                     || (key_wr && pend_q && !good_feed && !good_soft)
                     || (other_wr && pend_q);
    assign pend_d  = key_wr ? (!pend_q && first_ok)
                            : (other_wr ? 1'b0 : pend_q);
    assign first_d = key_wr ? kb : first_q;
    // helper state, short on purpose
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pend_q  <= 1'b0;
            first_q <= 8'h00;
        end else begin
            pend_q  <= pend_d;
            first_q <= first_d;
        end
    end
    // ----------------------------------------------------------------
    // sequences and properties
    // ----------------------------------------------------------------
    sequence s_setup; psel && !penable; endsequence
    sequence s_access;
        (penable && !pready) ##1 (penable && pready);
    endsequence
    sequence s_pulse; cpu_reset_pulse ##1 !cpu_reset_pulse; endsequence
    property p_one_wait; s_setup |=> s_access; endproperty
    property p_ready_pulse; pready |=> !pready; endproperty
    property p_err_ready; pslverr |-> pready && penable; endproperty
    property p_soft; good_soft |=> s_pulse; endproperty
    property p_bad; bad |=> s_pulse; endproperty
    property p_feed; good_feed |=> watchdog_running && !cpu_reset_pulse;
    endproperty
    property p_run_cause; $rose(watchdog_running) |-> $past(good_feed);
    endproperty
    property p_pulse_cause;
        $rose(cpu_reset_pulse) |->
            $past(good_soft) || $past(bad) || $past(watchdog_running);
    endproperty
    property p_pd; power_down ##1 power_down |-> !watchdog_running;
    endproperty
    property p_stop; cpu_reset_pulse |=> !watchdog_running; endproperty
    property p_key_rd;
        psel && penable && pready && !pwrite && paddr == key_a
            |-> prdata == 32'h0;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("bad wait state");
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
    a_err_ready: assert property (p_err_ready) else $error("stray pslverr");
    a_soft: assert property (p_soft) else $error("no soft pulse");
    a_bad: assert property (p_bad) else $error("no error pulse");
    a_feed: assert property (p_feed)
        else $error("feed not running");
    a_run_cause: assert property (p_run_cause)
        else $error("run no feed");
    a_pulse_cause: assert property (p_pulse_cause)
        else $error("pulse why");
    a_pd: assert property (p_pd) else $error("runs in power down");
    a_stop: assert property (p_stop)
        else $error("runs after pulse");
    a_key_rd: assert property (p_key_rd)
        else $error("key readable");
endmodule : wdt_key_ctrl_properties

bind wdt_key_ctrl wdt_key_ctrl_properties #(
    .PRESCALE_W (PRESCALE_W)
) wdt_key_ctrl_properties_inst (
    .clk_sys          (clk_sys),
    .rst_n            (rst_n),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .cpu_idle         (cpu_idle),
    .power_down       (power_down),
    .cpu_reset_pulse  (cpu_reset_pulse),
    .watchdog_running (watchdog_running),
    .irq              (irq)
);

// file: wdt_key_ctrl_tb.sv
// self-checking bench of the watchdog key block
`timescale 1ns/1ns
module wdt_key_ctrl_tb;
    import wdt_pkg::*;
    localparam logic [11:0] A_CTL = {IDX_CTRL_STATUS, 2'b00};
    localparam logic [11:0] A_KEY = {IDX_KEY, 2'b00};
    localparam logic [11:0] A_IST = {IDX_IRQ_STATUS, 2'b00};
    localparam logic [11:0] A_MSK = {IDX_IRQ_MASK, 2'b00};
    localparam logic [11:0] A_BAD = 12'hFF0;
    logic        clk_sys, rst_n, psel, penable, pwrite;
    logic        cpu_idle, power_down, pready, pslverr, er;
    logic        cpu_reset_pulse, watchdog_running, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  fb [4] = '{8'h33, 8'h1E, 8'h5A, 8'h1E};
    logic [7:0]  sb [4] = '{8'h00, 8'hA5, 8'hE1, 8'h00};
    int          n_fail = 0, n_compared = 0, n_pulse = 0, cyc;
    // short prescaler: timeout is 2^(9 + period) cycles
    wdt_key_ctrl #(
        .PRESCALE_W (2)
    ) wdt_key_ctrl_inst (
        .clk_sys          (clk_sys),
        .rst_n            (rst_n),
        .psel             (psel),
        .penable          (penable),
        .pwrite           (pwrite),
        .paddr            (paddr),
        .pwdata           (pwdata),
        .prdata           (prdata),
        .pready           (pready),
        .pslverr          (pslverr),
        .cpu_idle         (cpu_idle),
        .power_down       (power_down),
        .cpu_reset_pulse  (cpu_reset_pulse),
        .watchdog_running (watchdog_running),
        .irq              (irq)
    );
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (cpu_reset_pulse === 1'b1) n_pulse++;
    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task close_out;
        if (n_fail == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        if (pready !== 1'b1) chk(32'h0, 32'h1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdc
    task feed;
        wr(A_KEY, {24'h0, KEY_FEED_FIRST});
        wr(A_KEY, {24'h0, KEY_FEED_SECOND});
    endtask : feed
    // wait for the reset pulse, cycles land in cyc
    task wait_pulse;
        cyc = 0;
        while (cpu_reset_pulse !== 1'b1 && cyc < 20000) begin
            @(posedge clk_sys);
            cyc++;
        end
    endtask : wait_pulse
    // hang guard, about twice the expected run
    initial begin
        #(40000 * 50);
        n_fail++;
        close_out;
    end
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        {psel, penable, pwrite, cpu_idle, power_down} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        rdc(A_CTL, 32'h0);
        rdc(A_KEY, 32'h0);
        apb(1'b0, A_BAD, 32'h0);
        chk({31'h0, er}, 32'h1);
        // soft reset with the counter stopped, a read inside the pair
        wr(A_MSK, 32'h1);
        wr(A_KEY, {24'h0, KEY_SOFT_FIRST});
        rdc(A_CTL, 32'h0);
        wr(A_KEY, {24'h0, KEY_SOFT_SECOND});
        rdc(A_CTL, 32'h04);
        chk(32'(n_pulse), 32'h1);
        rdc(A_IST, 32'h1);
        chk({31'h0, irq}, 32'h1);
        wr(A_MSK, 32'h0);
        repeat (2) @(posedge clk_sys);
        chk({31'h0, irq}, 32'h0);
        wr(A_IST, 32'h1);
        rdc(A_IST, 32'h0);
        wr(A_CTL, 32'h0);
        rdc(A_CTL, 32'h0);
        // wrong pairs; the last one is broken by a control write
        for (int i = 0; i < 4; i++) begin
            wr(A_KEY, {24'h0, fb[i]});
            if (i == 3) wr(A_CTL, 32'h0);
            else if (i > 0) wr(A_KEY, {24'h0, sb[i]});
            rdc(A_CTL, 32'h06);
            chk(32'(n_pulse), 32'(i + 2));
            wr(A_CTL, 32'h0);
        end
        // an unmapped write does not break a feed pair
        wr(A_KEY, {24'h0, KEY_FEED_FIRST});
        wr(A_BAD, 32'h0);
        wr(A_KEY, {24'h0, KEY_FEED_SECOND});
        rdc(A_CTL, 32'h01);
        rdc(A_IST, 32'hA);
        repeat (400) @(posedge clk_sys);
        feed;
        repeat (400) @(posedge clk_sys);
        chk(32'(n_pulse), 32'h5);
        // timeouts for period codes 0 to 4, idle does not freeze while bit 4 is clear
        cpu_idle <= 1'b1;
        for (int ps = 0; ps < 5; ps++) begin
            wr(A_CTL, 32'(ps << 5));
            feed;
            wait_pulse;
            chk(32'((cyc >> ps) inside {[508:516]}), 32'h1);
            rdc(A_CTL, 32'((ps << 5) | 2));
            wr(A_CTL, 32'(ps << 5));
        end
        rdc(A_IST, 32'hE);
        // idle freeze holds the count
        wr(A_CTL, 32'h10);
        feed;
        repeat (1500) @(posedge clk_sys);
        chk(32'(n_pulse), 32'hA);
        cpu_idle <= 1'b0;
        wait_pulse;
        chk(32'(cyc < 600), 32'h1);
        // power down stops the counter
        wr(A_CTL, 32'h0);
        feed;
        power_down <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk({31'h0, watchdog_running}, 32'h0);
        power_down <= 1'b0;
        // soft reset while the counter runs
        feed;
        wr(A_KEY, {24'h0, KEY_SOFT_FIRST});
        wr(A_KEY, {24'h0, KEY_SOFT_SECOND});
        rdc(A_CTL, 32'h04);
        chk(32'(n_pulse), 32'hC);
        close_out;
    end
endmodule : wdt_key_ctrl_tb
